// file: verilog/pm_cap_pkg.sv
// constants of the power management capability register pair
package pm_cap_pkg;
	localparam logic [11:0] CAP_OFFSET        = 12'h0_0a0;
	localparam logic [11:0] CTRL_OFFSET       = 12'h0_0a4;
	localparam logic [31:0] CAP_RESET         = 32'h7803_c001;
	localparam logic [31:0] CTRL_RESET        = 32'h0000_0008;
	localparam logic [4:0]  WAKE_STATES_DFLT  = 5'h0_f;
	localparam int          WAKE_STATES_LSB   = 27;
	localparam int          STATE2_SUP_BIT    = 26;
	localparam int          STATE1_SUP_BIT    = 25;
	localparam int          AUXILIARY_CURRENT_FIELD_LSB       = 22;
	localparam logic [2:0]  AUXILIARY_CURRENT_FIELD_VALUE     = 3'h0;
	localparam int          DSI_BIT           = 21;
	localparam int          WAKE_CLOCK_BIT    = 19;
	localparam int          VERSION_LSB       = 16;
	localparam logic [2:0]  VERSION_VALUE     = 3'h3;
	localparam int          NEXT_PTR_LSB      = 8;
	localparam logic [7:0]  NEXT_PTR_VALUE    = 8'hc0;
	localparam logic [7:0]  CAPABILITY_IDENTIFIER_VALUE      = 8'h01;
	localparam int          WAKE_STATUS_BIT   = 15;
	localparam int          WAKE_ENABLE_BIT   = 8;
	localparam int          NO_SOFT_RST_BIT   = 3;
	localparam int          POWER_STATE_LSB   = 0;
	localparam logic [1:0]  STATE_D0          = 2'h0;
	localparam logic [1:0]  STATE_D1          = 2'h1;
	localparam logic [1:0]  STATE_D2          = 2'h2;
	localparam logic [1:0]  STATE_D3HOT       = 2'h3;
endpackage

// file: verilog/pm_sync2.sv
// two flip-flop synchroniser for a level
`timescale 1ns/1ns
`default_nettype none
module pm_sync2 (
	input  wire logic mclk,   // clock
	input  wire logic nrst,   // async reset, active low
	input  wire logic din,    // asynchronous level
	output var  logic dout    // synchronised level
);
	logic stage1;

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			stage1 <= 1'b0;
			dout   <= 1'b0;
		end else begin
			stage1 <= din;
			dout   <= stage1;
		end
	end
endmodule // pm_sync2
`default_nettype wire

// file: verilog/power_mgmt_capability_regs.sv
// power management capability and control/status registers
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// [R1] wake-capable states reported in capability bits 31:27, taken from EEPROM setting
// [R2] without EEPROM information, wake-capable states read 01111
// [R3] state2_supported bit 26 always reads zero
// [R4] state1_supported bit 25 always reads zero
// [R5] auxiliary current field 24:22 reads 000, self powered
// [R6] device-specific initialization bit 21 reads zero
// [R7] wake clock bit 19 reads zero
// [R8] version field 18:16 reads 011
// [R9] next capability pointer 15:8 reads 0xC0
// [R10] capability identifier 7:0 reads 0x01
// [R11] control/status top byte reads 0x00
// [R12] data scale 14:13 and data select 12:9 read zero
// [R13] wake status bit 15 always reads zero, writes ignored
// [R14] wake enable bit 8 is read/write
// [R15] wake enable cleared at power-off, kept across cold-state exit
// [R16] no-soft-reset bit 3 always reads one
// [R17] power state field 1:0 read/write, 00 D0 to 11 D3hot
// [R18] writes of D1 or D2 are ignored, state unchanged
// [R19] reserved bits 23:16, 7:4 and 2 read zero
// [R20] only wake enable and power state change on writes
module power_mgmt_capability_regs (
	input  wire logic        mclk,          // configuration clock, 10 MHz
	input  wire logic        nrst,          // reset, active low, asynchronous
	input  wire logic        powerOnReset,  // pin: high when reset comes from power-off
	input  wire logic        eepromValid,   // pin: EEPROM contents were loaded
	input  wire logic [4:0]  eepromWakeStates, // wake states from EEPROM, static
	input  wire logic        cfgWrite,      // configuration write strobe
	input  wire logic        cfgRead,       // configuration read strobe
	input  wire logic [11:0] cfgAddr,       // configuration byte address
	input  wire logic [3:0]  cfgByteEn,     // byte enables of the write
	input  wire logic [31:0] cfgWriteData,  // write data
	output var  logic [31:0] cfgReadData,   // read data, registered
	output var  logic        cfgReadValid,  // read data valid, one cycle
	output var  logic        cfgHit,        // address hits this block
	output var  logic [1:0]  powerState,    // current power state
	output var  logic        wakeEnable     // wake event generation permitted
);
	import pm_cap_pkg::*;

	logic rstSync1;
	logic rstSync2;
	logic rst_n;
	logic porLevel;
	logic eeValidSync;
	logic [4:0] eeStatesMeta;
	logic [4:0] eeStatesSync;
	logic [4:0] wakeStates;
	logic [4:0] next_wakeStates;
	logic capturePending;
	logic [31:0] capWord;
	logic [31:0] ctrlWord;
	logic [1:0]  wrState;

	// reset release through two flops
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			rstSync1 <= 1'b0;
			rstSync2 <= 1'b0;
		end else begin
			rstSync1 <= 1'b1;
			rstSync2 <= rstSync1;
		end
	end
	assign rst_n = rstSync2;

	// the pin synchronisers run on the raw reset so that their levels are
	// already settled at the edge where the internal reset releases
	pm_sync2 uPorSync (
		.mclk (mclk),
		.nrst (nrst),
		.din  (powerOnReset),
		.dout (porLevel)
	);

	pm_sync2 uEeSync (
		.mclk (mclk),
		.nrst (nrst),
		.din  (eepromValid),
		.dout (eeValidSync)
	);

	// the EEPROM setting is a pin level, so it passes two flops as well
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			eeStatesMeta <= WAKE_STATES_DFLT;
			eeStatesSync <= WAKE_STATES_DFLT;
		end else begin
			eeStatesMeta <= eepromWakeStates;
			eeStatesSync <= eeStatesMeta;
		end
	end

	function automatic logic hits(input logic [11:0] a, input logic [11:0] off);
		hits = (a[11:2] == off[11:2]);
	endfunction

	always_comb begin
		next_wakeStates = eeValidSync ? eeStatesSync : WAKE_STATES_DFLT; // [R1] [R2]
	end

	// the wake states reload every cycle from the synchronised EEPROM setting, or the default without it
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			wakeStates <= WAKE_STATES_DFLT; // [R2]
		end else begin
			wakeStates <= next_wakeStates; // [R1]
		end
	end

	always_comb begin
		capWord = 32'h0000_0000;
		capWord[WAKE_STATES_LSB +: 5] = wakeStates;  // [R1]
		capWord[STATE2_SUP_BIT] = 1'b0;              // [R3]
		capWord[STATE1_SUP_BIT] = 1'b0;              // [R4]
		capWord[AUXILIARY_CURRENT_FIELD_LSB +: 3] = AUXILIARY_CURRENT_FIELD_VALUE;   // [R5]
		capWord[DSI_BIT] = 1'b0;                     // [R6]
		capWord[WAKE_CLOCK_BIT] = 1'b0;              // [R7]
		capWord[VERSION_LSB +: 3] = VERSION_VALUE;   // [R8]
		capWord[NEXT_PTR_LSB +: 8] = NEXT_PTR_VALUE; // [R9]
		capWord[7:0] = CAPABILITY_IDENTIFIER_VALUE;                 // [R10]
	end

	// top byte, data fields, status and reserved bits stay zero
	always_comb begin
		ctrlWord = 32'h0000_0000;                    // [R11] [R12] [R13] [R19]
		ctrlWord[WAKE_ENABLE_BIT] = wakeEnable;      // [R14]
		ctrlWord[NO_SOFT_RST_BIT] = 1'b1;            // [R16]
		ctrlWord[POWER_STATE_LSB +: 2] = powerState; // [R17]
	end

	assign wrState = cfgWriteData[POWER_STATE_LSB +: 2];

	// power state: D1 and D2 are not implemented, such writes leave the state
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			powerState <= STATE_D0;
		end else if (cfgWrite && hits(cfgAddr, CTRL_OFFSET) && cfgByteEn[0]) begin // [R20]
			if (wrState == STATE_D0 || wrState == STATE_D3HOT) begin // [R18]
				powerState <= wrState; // [R17]
			end
		end
	end

	// wake enable survives a cold-state reset, so it clears only on power-off;
	// the power-off level is sampled after release since async reset takes constants
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			capturePending <= 1'b1;
		end else if (rstSync2) begin
			capturePending <= 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (capturePending && rstSync2 && porLevel) begin
			wakeEnable <= 1'b0; // [R15]
		end else if (rst_n && cfgWrite && hits(cfgAddr, CTRL_OFFSET) && cfgByteEn[1]) begin // [R20]
			wakeEnable <= cfgWriteData[WAKE_ENABLE_BIT]; // [R14]
		end
	end

	assign cfgHit = hits(cfgAddr, CAP_OFFSET) || hits(cfgAddr, CTRL_OFFSET);

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cfgReadData  <= 32'h0000_0000;
			cfgReadValid <= 1'b0;
		end else begin
			cfgReadValid <= cfgRead;
			if (cfgRead) begin
				if (hits(cfgAddr, CAP_OFFSET)) begin
					cfgReadData <= capWord;
				end else if (hits(cfgAddr, CTRL_OFFSET)) begin
					cfgReadData <= ctrlWord;
				end else begin
					cfgReadData <= 32'h0000_0000;
				end
			end
		end
	end

	a_cap_fixed: assert property (@(posedge mclk) disable iff (!rst_n)
		cfgRead && hits(cfgAddr, CAP_OFFSET) |=> cfgReadValid
		&& cfgReadData[26:0] == CAP_RESET[26:0]) // [R3]
		else $error("capability word fixed fields wrong");
	a_wake_states: assert property (@(posedge mclk) disable iff (!rst_n)
		cfgRead && hits(cfgAddr, CAP_OFFSET) && !eeValidSync && !$past(eeValidSync)
		|=> cfgReadData[31:27] == WAKE_STATES_DFLT) // [R2]
		else $error("default wake states wrong");
	a_ctrl_zero: assert property (@(posedge mclk) disable iff (!rst_n)
		cfgRead && hits(cfgAddr, CTRL_OFFSET)
		|=> (cfgReadData & 32'hffff_fef4) == 32'h0000_0000) // [R19]
		else $error("control reserved bits not zero");
	a_no_soft: assert property (@(posedge mclk) disable iff (!rst_n)
		cfgRead && hits(cfgAddr, CTRL_OFFSET) |=> cfgReadData[3]) // [R16]
		else $error("no soft reset bit not one");
	a_state_legal: assert property (@(posedge mclk) disable iff (!rst_n)
		powerState == STATE_D0 || powerState == STATE_D3HOT) // [R18]
		else $error("unsupported power state held");
	a_state_write: assert property (@(posedge mclk) disable iff (!rst_n)
		cfgWrite && hits(cfgAddr, CTRL_OFFSET) && cfgByteEn[0] && wrState == STATE_D3HOT
		|=> powerState == STATE_D3HOT) // [R17]
		else $error("power state write lost");
	a_state_hold: assert property (@(posedge mclk) disable iff (!rst_n)
		!(cfgWrite && hits(cfgAddr, CTRL_OFFSET)) |=> $stable(powerState)) // [R20]
		else $error("power state changed without write");
	a_wake_write: assert property (@(posedge mclk) disable iff (!rst_n)
		cfgWrite && hits(cfgAddr, CTRL_OFFSET) && cfgByteEn[1] && !capturePending
		|=> wakeEnable == $past(cfgWriteData[8])) // [R14]
		else $error("wake enable write lost");
	a_read_pair: assert property (@(posedge mclk) disable iff (!rst_n)
		cfgRead && hits(cfgAddr, CTRL_OFFSET)
		|=> cfgReadData[1:0] == $past(powerState) && cfgReadData[8] == $past(wakeEnable)) // [R17]
		else $error("control read mismatch");

	// request shapes shared by the field checks below
	sequence s_cap_read;
		cfgRead && hits(cfgAddr, CAP_OFFSET);
	endsequence

	sequence s_ctrl_read;
		cfgRead && hits(cfgAddr, CTRL_OFFSET);
	endsequence

	sequence s_cap_write;
		cfgWrite && hits(cfgAddr, CAP_OFFSET) && !capturePending;
	endsequence

	a_wake_source: assert property (@(posedge mclk) disable iff (!rst_n) // [R1]
		cfgRead && hits(cfgAddr, CAP_OFFSET) && $past(eeValidSync)
		|=> cfgReadData[31:27] == $past(eeStatesSync, 2))
		else $error("wake states not taken from EEPROM setting");

	a_state2_zero: assert property (@(posedge mclk) disable iff (!rst_n) // [R3]
		s_cap_read |=> !cfgReadData[26])
		else $error("state2 supported bit set");

	a_state1_zero: assert property (@(posedge mclk) disable iff (!rst_n) // [R4]
		s_cap_read |=> !cfgReadData[25])
		else $error("state1 supported bit set");

	a_aux_current: assert property (@(posedge mclk) disable iff (!rst_n) // [R5]
		s_cap_read |=> cfgReadData[24:22] == AUXILIARY_CURRENT_FIELD_VALUE)
		else $error("auxiliary current field wrong");

	a_dsi_zero: assert property (@(posedge mclk) disable iff (!rst_n) // [R6]
		s_cap_read |=> !cfgReadData[21])
		else $error("initialization bit set");

	a_wake_clock: assert property (@(posedge mclk) disable iff (!rst_n) // [R7]
		s_cap_read |=> !cfgReadData[20] && !cfgReadData[19])
		else $error("wake clock or reserved bit set");

	a_version_field: assert property (@(posedge mclk) disable iff (!rst_n) // [R8]
		s_cap_read |=> cfgReadData[18:16] == VERSION_VALUE)
		else $error("version field wrong");

	a_next_pointer: assert property (@(posedge mclk) disable iff (!rst_n) // [R9]
		s_cap_read |=> cfgReadData[15:8] == NEXT_PTR_VALUE)
		else $error("next capability pointer wrong");

	a_cap_ident: assert property (@(posedge mclk) disable iff (!rst_n) // [R10]
		s_cap_read |=> cfgReadData[7:0] == CAPABILITY_IDENTIFIER_VALUE)
		else $error("capability identifier wrong");

	a_data_byte: assert property (@(posedge mclk) disable iff (!rst_n) // [R11]
		s_ctrl_read |=> cfgReadData[31:24] == 8'h00)
		else $error("power data byte not zero");

	a_data_fields: assert property (@(posedge mclk) disable iff (!rst_n) // [R12]
		s_ctrl_read |=> cfgReadData[14:9] == 6'h00)
		else $error("data scale or select not zero");

	a_status_zero: assert property (@(posedge mclk) disable iff (!rst_n) // [R13]
		s_ctrl_read |=> !cfgReadData[15])
		else $error("wake status bit set");

	a_reserved_mid: assert property (@(posedge mclk) disable iff (!rst_n) // [R19]
		s_ctrl_read |=> cfgReadData[23:16] == 8'h00)
		else $error("reserved middle byte not zero");

	a_reserved_low: assert property (@(posedge mclk) disable iff (!rst_n) // [R19]
		s_ctrl_read |=> cfgReadData[7:4] == 4'h0 && !cfgReadData[2])
		else $error("reserved low bits not zero");

	a_wake_poweroff: assert property (@(posedge mclk) disable iff (!rst_n) // [R15]
		capturePending && porLevel |=> !wakeEnable)
		else $error("wake enable kept after power-off");

	a_state_refuse: assert property (@(posedge mclk) disable iff (!rst_n) // [R18]
		cfgWrite && hits(cfgAddr, CTRL_OFFSET) && cfgByteEn[0]
		&& (wrState == STATE_D1 || wrState == STATE_D2) |=> $stable(powerState))
		else $error("unsupported power state accepted");

	a_state_d0: assert property (@(posedge mclk) disable iff (!rst_n) // [R17]
		cfgWrite && hits(cfgAddr, CTRL_OFFSET) && cfgByteEn[0] && wrState == STATE_D0
		|=> powerState == STATE_D0)
		else $error("power state write to D0 lost");

	a_wake_hold: assert property (@(posedge mclk) disable iff (!rst_n) // [R20]
		!(cfgWrite && hits(cfgAddr, CTRL_OFFSET) && cfgByteEn[1]) && !capturePending
		|=> $stable(wakeEnable))
		else $error("wake enable changed without write");

	a_cap_write: assert property (@(posedge mclk) disable iff (!rst_n) // [R20]
		s_cap_write |=> $stable(powerState) && $stable(wakeEnable))
		else $error("capability write changed state");

	a_unmapped_read: assert property (@(posedge mclk) disable iff (!rst_n) // [R20]
		cfgRead && !cfgHit |=> cfgReadData == 32'h0000_0000)
		else $error("unmapped read not zero");
endmodule // power_mgmt_capability_regs
`default_nettype wire

// file: sim/cfg_host.sv
// configuration requester model facing the register pair
`timescale 1ns/1ns
`default_nettype none
module cfg_host (
	input  wire logic        mclk,         // clock
	input  wire logic [31:0] cfgReadData,  // read data
	input  wire logic        cfgReadValid, // read data valid
	output var  logic        cfgWrite,     // write strobe
	output var  logic        cfgRead,      // read strobe
	output var  logic [11:0] cfgAddr,      // byte address
	output var  logic [3:0]  cfgByteEn,    // byte enables
	output var  logic [31:0] cfgWriteData  // write data
);
	initial begin
		{cfgWrite, cfgRead, cfgAddr, cfgByteEn, cfgWriteData} = '0;
	end
	// strobes stay up between requests, so back to back calls never toggle them twice
	task wr(input logic [11:0] a, input logic [3:0] be, input logic [31:0] d);
		{cfgAddr, cfgByteEn, cfgWriteData, cfgWrite, cfgRead} = {a, be, d, 2'b10};
		@(posedge mclk);
		#1;
	endtask
	// answer is sampled 1 ns after the taking edge; a missing answer reads as unknown
	task rd(input logic [11:0] a, output logic [31:0] d);
		{cfgAddr, cfgWrite, cfgRead} = {a, 2'b01};
		@(posedge mclk);
		#1;
		d = (cfgReadValid === 1'b1) ? cfgReadData : 'x;
	endtask
	// released fields show the bitwise inverse of their last value, never the last value
	task idle();
		{cfgWrite, cfgRead} = 2'b00;
		{cfgAddr, cfgByteEn, cfgWriteData} = ~{cfgAddr, cfgByteEn, cfgWriteData};
	endtask
endmodule // cfg_host
`default_nettype wire

// file: sim/tb_top.sv
// self-checking bench for the power management register pair
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import pm_cap_pkg::*;
	logic        mclk, nrst, powerOnReset, eepromValid;
	logic        cfgWrite, cfgRead, cfgReadValid, cfgHit, wakeEnable;
	logic [4:0]  eepromWakeStates;
	logic [11:0] cfgAddr, a;
	logic [3:0]  cfgByteEn;
	logic [31:0] cfgWriteData, cfgReadData, got, d;
	logic [1:0]  powerState;
	integer      fails = 0, compares = 0, seed = 32'h7b2c_dc2b, i, ps, we, ws;
	power_mgmt_capability_regs dut (.mclk(mclk), .nrst(nrst), .powerOnReset(powerOnReset),
		.eepromValid(eepromValid), .eepromWakeStates(eepromWakeStates), .cfgWrite(cfgWrite),
		.cfgRead(cfgRead), .cfgAddr(cfgAddr), .cfgByteEn(cfgByteEn), .cfgWriteData(cfgWriteData),
		.cfgReadData(cfgReadData), .cfgReadValid(cfgReadValid), .cfgHit(cfgHit),
		.powerState(powerState), .wakeEnable(wakeEnable));
	cfg_host host (.mclk(mclk), .cfgReadData(cfgReadData), .cfgReadValid(cfgReadValid),
		.cfgWrite(cfgWrite), .cfgRead(cfgRead), .cfgAddr(cfgAddr), .cfgByteEn(cfgByteEn),
		.cfgWriteData(cfgWriteData));
	always #50 mclk = ~mclk;
	task chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			fails++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task give_verdict();
		$display("comparisons %0d mismatches %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task rst(input logic por);
		host.idle();
		powerOnReset = por;
		nrst = 1'b0;
		repeat (10) @(posedge mclk);
		#1 nrst = 1'b1;
		repeat (4) @(posedge mclk);
		#1 ps = 0;
		if (por)
			we = 0;
	endtask
	task verify();
		host.rd(CAP_OFFSET, got);
		chk(got, {ws[4:0], 2'b00, AUXILIARY_CURRENT_FIELD_VALUE, 3'b000, VERSION_VALUE, NEXT_PTR_VALUE,
			CAPABILITY_IDENTIFIER_VALUE});
		host.rd(CTRL_OFFSET, got);
		chk(got, {23'h0, we[0], 4'h0, 2'b10, ps[1:0]});
		chk({30'h0, powerState}, ps);
		chk({31'h0, wakeEnable}, we);
	endtask
	initial begin
		{nrst, eepromValid, eepromWakeStates, mclk} = '0;
		powerOnReset = 1'b1;
		{we, ws} = {32'd0, 32'd15};
		rst(1'b1);
		verify();
		$display("reset values test done");
		for (i = 0; i < 40; i++) begin
			d = $random(seed);
			got = $random(seed);
			a = (i % 4 == 2) ? CAP_OFFSET : ((i % 4 == 3) ? 12'h0_0a8 : CTRL_OFFSET);
			host.wr(a, got[3:0], d);
			chk({31'h0, cfgHit}, (a == 12'h0_0a8) ? 0 : 1);
			if (a == CTRL_OFFSET && got[1])
				we = d[8];
			if (a == CTRL_OFFSET && got[0] && (d[1:0] == 2'b00 || d[1:0] == 2'b11))
				ps = d[1:0];
			verify();
			host.rd(12'h0_0a8, got);
			chk(got, 32'h0000_0000);
		end
		$display("random write test done");
		host.idle();
		eepromValid = 1'b1;
		eepromWakeStates = $random(seed);
		ws = eepromWakeStates;
		repeat (4) @(posedge mclk);
		#1 verify();
		$display("wake states test done");
		host.wr(CTRL_OFFSET, 4'hf, 32'h0000_0103);
		{we, ps} = {32'd1, 32'd3};
		rst(1'b0);
		verify();
		rst(1'b1);
		verify();
		$display("reset kinds test done");
		give_verdict();
	end
	initial begin
		#1_000_000;
		fails++;
		$display("unexpected at %0t: watchdog expired", $time);
		give_verdict();
	end
endmodule // tb_top
`default_nettype wire
